// [rtl/oamu_defines.vh]
/*
 * Constants for the operand address mode unit: specifier fields, mode codes,
 * step sizes and special register numbers.
 * Assumes it is included by bare name from files under rtl/.
 */
`ifndef OAMU_DEFINES_VH
`define OAMU_DEFINES_VH

// ----------------------------------------------------------------------------
// Operand specifier fields
// ----------------------------------------------------------------------------
`define OAMU_MODE_HI 5
`define OAMU_MODE_LO 3
`define OAMU_REG_HI 2
`define OAMU_REG_LO 0

// ----------------------------------------------------------------------------
// Addressing mode codes
// ----------------------------------------------------------------------------
`define OAMU_M_REG 3'h0
`define OAMU_M_REGDEF 3'h1
`define OAMU_M_AINC 3'h2
`define OAMU_M_AINCDEF 3'h3
`define OAMU_M_ADEC 3'h4
`define OAMU_M_ADECDEF 3'h5
`define OAMU_M_INDEX 3'h6
`define OAMU_M_INDEXDEF 3'h7

// ----------------------------------------------------------------------------
// Steps, special registers and reset values
// ----------------------------------------------------------------------------
`define OAMU_STEP_BYTE 16'h0001
`define OAMU_STEP_WORD 16'h0002
`define OAMU_SP 3'h6
`define OAMU_PC 3'h7
`define OAMU_ZERO16 16'h0000

`endif

// [rtl/oamu_regfile.v]
/*
 * Eight general registers with three registered read ports and one write port.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "oamu_defines.vh"

module oamu_regfile #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire CLOCK,
	input wire RSTN,
	// Write port
	input wire we,
	input wire [2:0] wsel,
	input wire [WIDTH-1:0] wdata,
	// Read ports
	input wire [2:0] asel,
	output reg [WIDTH-1:0] adata,
	input wire [2:0] csel,
	output reg [WIDTH-1:0] cdata,
	output reg [WIDTH-1:0] pcdata
);

	reg [WIDTH-1:0] mem [0:7];
	integer i;

	always @(posedge CLOCK) begin
		if (!RSTN) begin
			for (i = 0; i < 8; i = i + 1) begin
				mem[i] <= {WIDTH{1'b0}};
			end
			adata <= {WIDTH{1'b0}};
			cdata <= {WIDTH{1'b0}};
			pcdata <= {WIDTH{1'b0}};
		end else begin
			if (we) begin
				mem[wsel] <= wdata;
			end
			adata <= mem[asel];
			cdata <= mem[csel];
			pcdata <= mem[`OAMU_PC];
		end
	end

endmodule
`default_nettype wire

// [rtl/oamu_top.v]
/*
 * Operand address mode unit: decodes a six-bit operand specifier, updates the
 * general registers as the mode demands and fetches index words and pointers
 * from memory until the effective address is known.
 * Assumes the processor core issues one START at a time and that memory
 * answers a held read request with a one-cycle MEM_ACK and its data.
 */
// How it works
// [RL1] Word autoincrement: address is register value, then register gains two.
// [RL2] Byte autoincrement: address is register value, then register gains one.
// [RL3] Autodecrement: subtract one or two first, reduced value is the address.
// [RL4] Index: address is register plus fetched index word; neither is changed.
// [RL5] Two indexed operands take extension words in order, source then destination.
// [RL6] Register deferred: register value is the address; register unchanged.
// [RL7] Deferred auto and index modes add one memory read for the pointer.
// [RL8] Autoincrement deferred: read pointer at register, add two to register.
// [RL9] Index deferred: read pointer at register plus index; nothing modified.
// [RL10] Specifier bits five to three are mode, two to zero pick register.
// [RL11] Lowest mode bit selects the deferred variant of the basic mode.
// [RL12] Stack pointer and program counter always step by two.
// [RL13] Program counter advances by two past every index word fetched.
// [RL14] Autodecrement deferred always decrements by two before the pointer read.
`timescale 1ns/1ps
`default_nettype none
`include "oamu_defines.vh"

module oamu_top #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire CLOCK,
	input wire RSTN,
	// Request from the core
	input wire START,
	input wire [5:0] SPEC,
	input wire BYTE_OP,
	output reg BUSY,
	output reg DONE,
	output reg [WIDTH-1:0] EA,
	// Register load and readback for the core
	input wire REG_WE,
	input wire [2:0] REG_WSEL,
	input wire [WIDTH-1:0] REG_WDATA,
	input wire [2:0] REG_RSEL,
	output wire [WIDTH-1:0] REG_RDATA,
	// Memory read port
	output reg MEM_RD,
	output reg [WIDTH-1:0] MEM_ADDR,
	input wire MEM_ACK,
	input wire [WIDTH-1:0] MEM_RDATA
);

	// ------------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------------
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_RDREG = 5'h02;
	localparam [4:0] S_INDEX = 5'h04;
	localparam [4:0] S_PTR = 5'h08;
	localparam [4:0] S_DONE = 5'h10;

	function [WIDTH-1:0] step_of;
		input is_byte;
		input [2:0] rsel;
		begin
			if (is_byte && rsel != `OAMU_SP && rsel != `OAMU_PC) begin
				step_of = `OAMU_STEP_BYTE; // RL2
			end else begin
				step_of = `OAMU_STEP_WORD; // RL1 RL12
			end
		end
	endfunction

	reg [4:0] state_reg, state_next;
	reg [2:0] mode_reg, mode_next;
	reg [2:0] rsel_reg, rsel_next;
	reg byte_reg, byte_next;
	reg [WIDTH-1:0] ea_next, addr_next;
	reg rd_next, done_next;
	reg fsm_we;
	reg [2:0] fsm_wsel;
	reg [WIDTH-1:0] fsm_wdata;
	reg [WIDTH-1:0] base_reg, base_next;
	wire [WIDTH-1:0] rval, pcval;
	wire [WIDTH-1:0] pc_plus2 = pcval + `OAMU_STEP_WORD;

	// The core may only load registers while the unit is idle, so the two
	// write sources never collide and the decoder sees stable values.
	wire rf_we = fsm_we | (REG_WE & (state_reg == S_IDLE));
	wire [2:0] rf_wsel = fsm_we ? fsm_wsel : REG_WSEL;
	wire [WIDTH-1:0] rf_wdata = fsm_we ? fsm_wdata : REG_WDATA;
	wire [2:0] rf_asel = (state_reg == S_IDLE) ? SPEC[`OAMU_REG_HI:`OAMU_REG_LO] : rsel_reg;

	oamu_regfile #(
		.WIDTH(WIDTH)
	) u_regs (
		.CLOCK(CLOCK),
		.RSTN(RSTN),
		.we(rf_we),
		.wsel(rf_wsel),
		.wdata(rf_wdata),
		.asel(rf_asel),
		.adata(rval),
		.csel(REG_RSEL),
		.cdata(REG_RDATA),
		.pcdata(pcval)
	);

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		mode_next = mode_reg;
		rsel_next = rsel_reg;
		byte_next = byte_reg;
		ea_next = EA;
		addr_next = MEM_ADDR;
		rd_next = MEM_RD;
		done_next = 1'b0;
		fsm_we = 1'b0;
		fsm_wsel = rsel_reg;
		fsm_wdata = rval;
		base_next = base_reg;
		case (state_reg)
			S_IDLE: begin
				if (START) begin
					mode_next = SPEC[`OAMU_MODE_HI:`OAMU_MODE_LO]; // RL10
					rsel_next = SPEC[`OAMU_REG_HI:`OAMU_REG_LO]; // RL10
					byte_next = BYTE_OP;
					state_next = S_RDREG;
				end
			end
			S_RDREG: begin
				state_next = S_DONE;
				case (mode_reg)
					`OAMU_M_REG, `OAMU_M_REGDEF: begin
						ea_next = rval; // RL6
					end
					`OAMU_M_AINC: begin
						ea_next = rval; // RL1 RL2
						fsm_we = 1'b1;
						fsm_wdata = rval + step_of(byte_reg, rsel_reg); // RL1 RL2 RL12
					end
					`OAMU_M_AINCDEF: begin
						fsm_we = 1'b1;
						fsm_wdata = rval + `OAMU_STEP_WORD; // RL8 RL11
						addr_next = rval; // RL8 RL7
						rd_next = 1'b1;
						state_next = S_PTR;
					end
					`OAMU_M_ADEC: begin
						fsm_we = 1'b1;
						fsm_wdata = rval - step_of(byte_reg, rsel_reg); // RL3 RL12
						ea_next = fsm_wdata; // RL3
					end
					`OAMU_M_ADECDEF: begin
						fsm_we = 1'b1;
						fsm_wdata = rval - `OAMU_STEP_WORD; // RL14
						addr_next = fsm_wdata; // RL14 RL7
						rd_next = 1'b1;
						state_next = S_PTR;
					end
					default: begin
						// Index word sits at the PC; step the PC past it.
						fsm_we = 1'b1;
						fsm_wsel = `OAMU_PC;
						fsm_wdata = pc_plus2; // RL13 RL5
						addr_next = pcval; // RL4 RL5
						// The base is captured here because the PC read port shows
						// the stepped PC only from the second cycle on; a PC base must be
						// the PC after the index word, stepped only once.
						base_next = (rsel_reg == `OAMU_PC) ? pc_plus2 : rval; // RL4 RL13
						rd_next = 1'b1;
						state_next = S_INDEX;
					end
				endcase
			end
			S_INDEX: begin
				if (MEM_ACK) begin
					if (mode_reg[0]) begin // RL11
						addr_next = base_reg + MEM_RDATA; // RL9 RL7
						state_next = S_PTR;
					end else begin
						ea_next = base_reg + MEM_RDATA; // RL4
						rd_next = 1'b0;
						state_next = S_DONE;
					end
				end
			end
			S_PTR: begin
				if (MEM_ACK) begin
					ea_next = MEM_RDATA; // RL7 RL8 RL9
					rd_next = 1'b0;
					state_next = S_DONE;
				end
			end
			S_DONE: begin
				done_next = 1'b1;
				state_next = S_IDLE;
			end
			default: begin
				rd_next = 1'b0;
				state_next = S_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	always @(posedge CLOCK) begin
		if (!RSTN) begin
			state_reg <= S_IDLE;
			mode_reg <= `OAMU_M_REG;
			rsel_reg <= 3'h0;
			byte_reg <= 1'b0;
			base_reg <= `OAMU_ZERO16;
			EA <= `OAMU_ZERO16;
			MEM_ADDR <= `OAMU_ZERO16;
			MEM_RD <= 1'b0;
			DONE <= 1'b0;
			BUSY <= 1'b0;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			rsel_reg <= rsel_next;
			byte_reg <= byte_next;
			base_reg <= base_next;
			EA <= ea_next;
			MEM_ADDR <= addr_next;
			MEM_RD <= rd_next;
			DONE <= done_next;
			BUSY <= (state_next != S_IDLE);
		end
	end

endmodule
`default_nettype wire

// [sim/oamu_checker_assertions.sv]
/*
 * Port-level timing checks for the operand address mode unit.
 * Assumes one clock and that memory acks a held read with a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module oamu_checker #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// Core side
	input wire logic START,
	input wire logic [5:0] SPEC,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic [WIDTH-1:0] EA,
	// Memory side
	input wire logic MEM_RD,
	input wire logic [WIDTH-1:0] MEM_ADDR,
	input wire logic MEM_ACK
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	logic take;
	assign take = START && !BUSY;
	chk_direct_done: assert property (
		take && $countones(SPEC[5:3]) <= 1 |-> ##3 DONE) else $error("direct mode late");
	chk_index_read: assert property (
		take && SPEC[5:3] == 3'h6 |-> ##2 MEM_RD && !DONE) else $error("no index fetch");
	chk_defer_read: assert property (
		take && SPEC[3] && (SPEC[5] ^ SPEC[4]) |-> ##2 MEM_RD) else $error("no pointer read");
	chk_mode7_hold: assert property (
		take && SPEC[5:3] == 3'h7 |-> ##2 MEM_RD [*3]) else $error("mode 7 read dropped");
	chk_addr_hold: assert property (
		MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR)) else $error("read not held");
	chk_read_done: assert property (
		$fell(MEM_RD) |=> DONE) else $error("no result after read");
	chk_done_shape: assert property (
		DONE |-> !BUSY ##1 !DONE) else $error("bad result pulse");
	chk_ea_lead: assert property (
		$past(RSTN) && $changed(EA) |=> DONE) else $error("address moved without result");
endmodule
bind oamu_top oamu_checker #(.WIDTH(WIDTH)) u_chk (.CLOCK(CLOCK), .RSTN(RSTN),
	.START(START), .SPEC(SPEC), .BUSY(BUSY), .DONE(DONE), .EA(EA),
	.MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK));
`default_nettype wire

// [sim/oamu_mem_model.sv]
/*
 * Memory model: every word reads as its address plus 0x0100.
 * Assumes a level read request held until the one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none
module oamu_mem_model (
	// Clock
	input wire logic clk,
	// Read port
	input wire logic rd,
	input wire logic [15:0] addr,
	output logic ack,
	output logic [15:0] rdata
);
	logic [1:0] wait_reg;
	logic slow_reg;
	initial begin
		ack = 1'b0;
		rdata = 16'h0000;
		wait_reg = 2'h0;
		slow_reg = 1'b0;
	end
	// Answers alternate prompt and slow; data toggles when not valid.
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (rd && !ack) begin
			if (wait_reg == {slow_reg, 1'b0}) begin
				ack <= 1'b1;
				rdata <= addr + 16'h0100;
				wait_reg <= 2'h0;
				slow_reg <= ~slow_reg;
			end else begin
				wait_reg <= wait_reg + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [sim/tb_operand_address_mode_unit.sv]
/*
 * Testbench: runs every addressing mode and checks addresses and registers.
 * Assumes the memory model returns address plus 0x0100.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_operand_address_mode_unit;
	logic CLOCK, RSTN, START, BYTE_OP, BUSY, DONE, REG_WE, MEM_RD, MEM_ACK;
	logic [5:0] SPEC;
	logic [2:0] REG_WSEL, REG_RSEL;
	logic [15:0] EA, REG_WDATA, REG_RDATA, MEM_ADDR, MEM_RDATA, ea;
	int n_fail = 0;
	int total_checks = 0;
	oamu_top dut (.CLOCK(CLOCK), .RSTN(RSTN), .START(START), .SPEC(SPEC),
		.BYTE_OP(BYTE_OP), .BUSY(BUSY), .DONE(DONE), .EA(EA), .REG_WE(REG_WE),
		.REG_WSEL(REG_WSEL), .REG_WDATA(REG_WDATA), .REG_RSEL(REG_RSEL),
		.REG_RDATA(REG_RDATA), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
		.MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
	oamu_mem_model mem (.clk(CLOCK), .rd(MEM_RD), .addr(MEM_ADDR), .ack(MEM_ACK),
		.rdata(MEM_RDATA));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic put(input logic [2:0] r, input logic [15:0] v);
		REG_WE = 1;
		REG_WSEL = r;
		REG_WDATA = v;
		@(posedge CLOCK) #1 REG_WE = 0;
		// A spare edge keeps the strobe low between two writes.
		@(posedge CLOCK) #1;
	endtask
	task automatic rchk(input logic [2:0] r, input logic [15:0] exp);
		REG_RSEL = r;
		repeat (2) @(posedge CLOCK);
		#1 check(REG_RDATA, exp);
	endtask
	// Waits for the result under a bound; a hang counts as a mismatch.
	task automatic run(input logic [5:0] s, input logic b);
		int n = 0;
		START = 1;
		SPEC = s;
		BYTE_OP = b;
		@(posedge CLOCK) #1 START = 0;
		while (DONE !== 1'b1 && n < 40) begin
			@(posedge CLOCK) #1 n++;
		end
		if (n == 40) n_fail++;
		ea = EA;
		@(posedge CLOCK) #1;
	endtask
	task automatic t_auto();
		put(3'h5, 16'h1000);
		run(6'h15, 1'b0);
		check(ea, 16'h1000);
		rchk(3'h5, 16'h1002);
		run(6'h15, 1'b1);
		check(ea, 16'h1002);
		rchk(3'h5, 16'h1003);
		put(3'h6, 16'h0800);
		run(6'h16, 1'b1);
		rchk(3'h6, 16'h0802);
		run(6'h26, 1'b1);
		check(ea, 16'h0800);
	endtask
	task automatic t_dec();
		put(3'h0, 16'h2000);
		run(6'h20, 1'b0);
		check(ea, 16'h1ffe);
		run(6'h20, 1'b1);
		check(ea, 16'h1ffd);
		rchk(3'h0, 16'h1ffd);
	endtask
	task automatic t_index();
		put(3'h7, 16'h0100);
		put(3'h4, 16'h0200);
		put(3'h5, 16'h0300);
		run(6'h34, 1'b0);
		check(ea, 16'h0400);
		run(6'h35, 1'b0);
		check(ea, 16'h0502);
		rchk(3'h7, 16'h0104);
		rchk(3'h4, 16'h0200);
		run(6'h37, 1'b0);
		check(ea, 16'h030a);
		rchk(3'h7, 16'h0106);
	endtask
	task automatic t_defer();
		put(3'h1, 16'h0a00);
		run(6'h09, 1'b0);
		check(ea, 16'h0a00);
		rchk(3'h1, 16'h0a00);
		run(6'h01, 1'b0);
		check(ea, 16'h0a00);
		put(3'h2, 16'h0300);
		run(6'h1a, 1'b1);
		check(ea, 16'h0400);
		rchk(3'h2, 16'h0302);
		put(3'h3, 16'h0500);
		run(6'h2b, 1'b1);
		check(ea, 16'h05fe);
		rchk(3'h3, 16'h04fe);
		put(3'h7, 16'h0100);
		run(6'h3a, 1'b0);
		check(ea, 16'h0602);
		rchk(3'h2, 16'h0302);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		CLOCK = 0;
		forever #5 CLOCK = ~CLOCK;
	end
	initial begin
		#100000;
		n_fail++;
		test_done();
	end
	initial begin
		{RSTN, START, SPEC, BYTE_OP, REG_WE, REG_WSEL, REG_WDATA, REG_RSEL} = '0;
		repeat (5) @(posedge CLOCK);
		#1 RSTN = 1;
		t_auto();
		t_dec();
		t_index();
		t_defer();
		test_done();
	end
endmodule
`default_nettype wire
